/* File: logic/pwt_pkg.sv */
// Constants for the periodic wake-up timer: map, fields, divides.
// Assumes a 32-bit classic Wishbone register bus.
package pwt_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] ADDR_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_TICK_COUNT     = 8'h04;
  localparam logic [7:0] ADDR_MODULO         = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STATUS     = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK       = 8'h10;
  // ==========================================================
  // Fields of timer_status_control, plus the bit of irq status and mask
  localparam int PS_LSB = 0;
  localparam int PS_MSB = 3;
  localparam int IE_BIT = 4;
  localparam int CS_LSB = 5;
  localparam int CS_MSB = 6;
  localparam int MF_BIT = 7;
  localparam int IRQ_BIT = 0;
  // ==========================================================
  // Reset values and codes
  localparam logic [3:0] PS_OFF     = 4'h0;
  localparam logic [1:0] CS_LPO     = 2'h0;
  localparam logic [1:0] CS_EXT     = 2'h1;
  localparam logic [7:0] MOD_RESET  = 8'h00;
  localparam logic [7:0] CNT_ZERO   = 8'h00;
  localparam logic [7:0] CNT_ONE    = 8'h01;
  localparam int         N_PINS     = 7;
  // ==========================================================
  // Divide counts in source edges, slow and fast columns
  typedef logic [17:0] pwt_div_t;
  localparam pwt_div_t SLOW_BIN [8] = '{18'h00000, 18'h00008, 18'h00020,
    18'h00040, 18'h00080, 18'h00100, 18'h00200, 18'h00400};
  localparam pwt_div_t SLOW_DEC [8] = '{18'h00001, 18'h00002, 18'h00004,
    18'h0000A, 18'h00010, 18'h00064, 18'h001F4, 18'h003E8};
  localparam pwt_div_t FAST_BIN [8] = '{18'h00000, 18'h00400, 18'h00800,
    18'h01000, 18'h02000, 18'h04000, 18'h08000, 18'h10000};
  localparam pwt_div_t FAST_DEC [8] = '{18'h003E8, 18'h007D0, 18'h01388,
    18'h02710, 18'h04E20, 18'h0C350, 18'h186A0, 18'h30D40};
  localparam pwt_div_t DIV_ONE = 18'h00001;
  localparam pwt_div_t DIV_ZERO = 18'h00000;

  // Prescale code plus low source bit to edges per tick
  function automatic pwt_div_t pwt_div_count(input logic [3:0] ps,
                                             input logic       fast);
    if (ps[3]) begin
      return fast ? FAST_DEC[ps[2:0]] : SLOW_DEC[ps[2:0]];
    end
    return fast ? FAST_BIN[ps[2:0]] : SLOW_BIN[ps[2:0]];
  endfunction
endpackage

/* File: logic/pwt_timer.sv */
// Periodic wake-up timer: source select, prescaler, modulo counter,
// match flag and interrupt, behind a classic Wishbone slave.
// Assumes clock sources and power-mode levels arrive asynchronously.
//
// Chosen here: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps

module pwt_timer (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Clock sources, asynchronous
  input  wire logic        low_power_osc_i,
  input  wire logic        external_ref_clock_i,
  input  wire logic        internal_ref_clock_i,
  // Power modes, asynchronous levels
  input  wire logic        wait_mode_i,
  input  wire logic        deep_power_down_halt_i,
  input  wire logic        light_power_down_halt_i,
  input  wire logic        background_debug_i,
  // Requests
  output logic             irq_o,
  output logic             wake_o
);

  // ==========================================================
  // Input synchronisers
  logic [pwt_pkg::N_PINS-1:0] pin_raw;
  logic [pwt_pkg::N_PINS-1:0] sync1_reg;
  logic [pwt_pkg::N_PINS-1:0] sync2_reg;
  logic [pwt_pkg::N_PINS-1:0] sync3_reg;

  assign pin_raw = {background_debug_i, light_power_down_halt_i,
                    deep_power_down_halt_i, wait_mode_i,
                    internal_ref_clock_i, external_ref_clock_i,
                    low_power_osc_i};

  // Two flops per pin, a third only for edge finding
  genvar gi;
  generate
    for (gi = 0; gi < pwt_pkg::N_PINS; gi++) begin : g_sync
      always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
          sync3_reg[gi] <= 1'b0;
        end else begin
          sync1_reg[gi] <= pin_raw[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          sync3_reg[gi] <= sync2_reg[gi];
        end
      end
    end
  endgenerate

  logic [2:0] src_edge;
  logic       wait_s;
  logic       deep_s;
  logic       light_s;
  logic       debug_s;

  // Rising edges of the three sources
  assign src_edge = sync2_reg[2:0] & ~sync3_reg[2:0];
  assign wait_s   = sync2_reg[3];
  assign deep_s   = sync2_reg[4];
  assign light_s  = sync2_reg[5];
  assign debug_s  = sync2_reg[6];

  // ==========================================================
  // Register state
  logic [3:0] prescale_select_reg;
  logic [1:0] clock_source_select_reg;
  logic       match_irq_enable_reg;
  logic       match_flag_reg;
  logic [7:0] modulo_compare_reg;
  logic [7:0] tick_count_reg;
  logic [17:0] presc_reg;

  // Bus decode
  logic bus_req;
  logic wr_lane0;
  logic wr_sc;
  logic wr_mod;
  logic wr_istat;
  logic wr_imask;
  logic clear_counts;
  logic flag_clear_req;

  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] want);
    return a == want;
  endfunction

  // One request per ack; ack drops the cycle after
  assign bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_lane0 = bus_req & wb_we_i & wb_sel_i[0];
  assign wr_sc    = wr_lane0 & hit(wb_adr_i, pwt_pkg::ADDR_STATUS_CONTROL);
  assign wr_mod   = wr_lane0 & hit(wb_adr_i, pwt_pkg::ADDR_MODULO);
  assign wr_istat = wr_lane0 & hit(wb_adr_i, pwt_pkg::ADDR_IRQ_STATUS);
  assign wr_imask = wr_lane0 & hit(wb_adr_i, pwt_pkg::ADDR_IRQ_MASK);

  // Restart on a new prescale code or any modulo write
  assign clear_counts = (wr_sc & (wb_dat_i[pwt_pkg::PS_MSB:pwt_pkg::PS_LSB]
                                  != prescale_select_reg))
                      | wr_mod;

  // Only a one clears; a zero leaves the flag alone
  assign flag_clear_req = (wr_sc & wb_dat_i[pwt_pkg::MF_BIT])
                        | (wr_istat & wb_dat_i[pwt_pkg::IRQ_BIT]);

  // ==========================================================
  // Control registers
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      prescale_select_reg     <= pwt_pkg::PS_OFF;
      clock_source_select_reg <= pwt_pkg::CS_LPO;
      match_irq_enable_reg    <= 1'b0;
    end else if (wr_sc) begin
      prescale_select_reg     <= wb_dat_i[pwt_pkg::PS_MSB:pwt_pkg::PS_LSB];
      clock_source_select_reg <= wb_dat_i[pwt_pkg::CS_MSB:pwt_pkg::CS_LSB];
      match_irq_enable_reg    <= wb_dat_i[pwt_pkg::IE_BIT];
    end else if (wr_imask) begin
      match_irq_enable_reg    <= wb_dat_i[pwt_pkg::IRQ_BIT];
    end
  end

  // Any 8-bit value is legal
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      modulo_compare_reg <= pwt_pkg::MOD_RESET;
    end else if (wr_mod) begin
      modulo_compare_reg <= wb_dat_i[7:0];
    end
  end

  // ==========================================================
  // Prescaler
  logic        sel_edge;
  logic        src_avail;
  logic        run;
  logic        tick;
  logic [17:0] div_count;

  // Both internal-ref codes share one source pin
  always_comb begin
    case (clock_source_select_reg)
      pwt_pkg::CS_LPO: sel_edge = src_edge[0];
      pwt_pkg::CS_EXT: sel_edge = src_edge[1];
      default:         sel_edge = src_edge[2];
    endcase
  end

  // Deep halt keeps only the slow oscillator alive
  assign src_avail = (clock_source_select_reg == pwt_pkg::CS_LPO)
                   | ~deep_s;

  // Wait and light halt do not stop the count; deep halt stops it unless the source is the slow oscillator
  assign run = (prescale_select_reg != pwt_pkg::PS_OFF)
             & ~debug_s
             & src_avail;

  // Low source bit picks the column of divides
  assign div_count = pwt_pkg::pwt_div_count(prescale_select_reg,
                                            clock_source_select_reg[0]);

  assign tick = run & sel_edge & (presc_reg == div_count - pwt_pkg::DIV_ONE);

  // Source edges counted up to the divide
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      presc_reg <= pwt_pkg::DIV_ZERO;
    end else if (clear_counts) begin
      presc_reg <= pwt_pkg::DIV_ZERO;
    end else if (tick) begin
      presc_reg <= pwt_pkg::DIV_ZERO;
    end else if (run & sel_edge) begin
      presc_reg <= presc_reg + pwt_pkg::DIV_ONE;
    end
  end

  // ==========================================================
  // Modulo counter and match flag
  logic at_modulo;
  logic match_event;

  assign at_modulo   = tick_count_reg == modulo_compare_reg;
  assign match_event = tick & at_modulo & ~clear_counts;

  // Held value survives debug since nothing here moves without a tick or a clearing write
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      tick_count_reg <= pwt_pkg::CNT_ZERO;
    end else if (clear_counts) begin
      tick_count_reg <= pwt_pkg::CNT_ZERO;
    end else if (tick) begin
      if (at_modulo) begin
        tick_count_reg <= pwt_pkg::CNT_ZERO;
      end else begin
        tick_count_reg <= tick_count_reg + pwt_pkg::CNT_ONE;
      end
    end
  end

  // Set wins over a clearing write in the same cycle
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      match_flag_reg <= 1'b0;
    end else if (match_event) begin
      match_flag_reg <= 1'b1;
    end else if (flag_clear_req) begin
      match_flag_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Interrupt and wake, one cycle behind the flag
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      irq_o  <= 1'b0;
      wake_o <= 1'b0;
    end else begin
      irq_o  <= match_flag_reg & match_irq_enable_reg;
      wake_o <= match_flag_reg & match_irq_enable_reg
              & (wait_s | deep_s | light_s)
              & src_avail & run;
    end
  end

  // ==========================================================
  // Bus answer: always one cycle, unmapped reads zero
  logic [31:0] rd_data;

  always_comb begin
    rd_data = '0;
    case (wb_adr_i)
      pwt_pkg::ADDR_STATUS_CONTROL: begin
        rd_data[pwt_pkg::PS_MSB:pwt_pkg::PS_LSB] = prescale_select_reg;
        rd_data[pwt_pkg::IE_BIT]                 = match_irq_enable_reg;
        rd_data[pwt_pkg::CS_MSB:pwt_pkg::CS_LSB] = clock_source_select_reg;
        rd_data[pwt_pkg::MF_BIT]                 = match_flag_reg;
      end
      pwt_pkg::ADDR_TICK_COUNT: rd_data[7:0] = tick_count_reg;
      pwt_pkg::ADDR_MODULO:     rd_data[7:0] = modulo_compare_reg;
      pwt_pkg::ADDR_IRQ_STATUS: rd_data[pwt_pkg::IRQ_BIT] = match_flag_reg;
      pwt_pkg::ADDR_IRQ_MASK:   rd_data[pwt_pkg::IRQ_BIT] = match_irq_enable_reg;
      default:                  rd_data = '0;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= (bus_req & ~wb_we_i) ? rd_data : '0;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  a_wrap_to_zero: assert property (
    tick && at_modulo && !clear_counts |=> tick_count_reg == pwt_pkg::CNT_ZERO)
    else $error("counter did not wrap at modulo");

  a_count_step: assert property (
    tick && !at_modulo && !clear_counts
    |=> tick_count_reg == 8'($past(tick_count_reg) + pwt_pkg::CNT_ONE))
    else $error("counter did not step by one");

  a_flag_on_wrap: assert property (
    match_event |=> match_flag_reg && tick_count_reg == pwt_pkg::CNT_ZERO)
    else $error("flag not set on wrap");

  a_set_beats_clear: assert property (
    match_event && flag_clear_req |=> match_flag_reg)
    else $error("clear beat a same-cycle match");

  a_flag_w1c: assert property (
    flag_clear_req && !match_event |=> !match_flag_reg)
    else $error("flag not cleared by writing one");

  a_zero_keeps: assert property (
    match_flag_reg && !flag_clear_req |=> match_flag_reg)
    else $error("flag lost without a clearing write");

  a_mod_restart: assert property (
    wr_mod |=> tick_count_reg == pwt_pkg::CNT_ZERO && presc_reg == pwt_pkg::DIV_ZERO)
    else $error("modulo write did not clear counters");

  a_ps_restart: assert property (
    wr_sc && wb_dat_i[pwt_pkg::PS_MSB:pwt_pkg::PS_LSB] != prescale_select_reg
    |=> tick_count_reg == pwt_pkg::CNT_ZERO && presc_reg == pwt_pkg::DIV_ZERO)
    else $error("new prescale did not clear counters");

  a_debug_freeze: assert property (
    debug_s && !clear_counts |=> $stable(tick_count_reg) && $stable(presc_reg))
    else $error("counting during debug");

  a_off_freeze: assert property (
    prescale_select_reg == pwt_pkg::PS_OFF && !clear_counts
    |=> $stable(tick_count_reg) [*2])
    else $error("counting with prescale off");

  a_deep_gate: assert property (
    deep_s && clock_source_select_reg != pwt_pkg::CS_LPO && !clear_counts
    |=> $stable(presc_reg))
    else $error("fast source ran in deep halt");

  a_irq_level: assert property (
    match_flag_reg && match_irq_enable_reg |=> irq_o)
    else $error("interrupt missing");

  a_no_dead_wake: assert property (
    !src_avail |=> !wake_o)
    else $error("wake without a clock source");

  a_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

  c_match: cover property (match_event);
  c_wake: cover property (wake_o && deep_s);
  c_set_clear: cover property (match_event && flag_clear_req);

endmodule // pwt_timer

/* File: testbench/tb_top.sv */
// Self-checking bench for the periodic wake-up timer.
// Assumes pwt_timer behind classic Wishbone, one 25 MHz clock.
`timescale 1ns/1ps

module tb_top;
  // ==========================================================
  // Bench signals
  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [3:0]  s;
    logic [31:0] d;
    logic [31:0] e;
  } pwt_row_t;
  logic        clock_i;
  logic        rst_b_i;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic [2:0]  src;
  logic        wait_m;
  logic        deep_m;
  logic        light_m;
  logic        bdm;
  logic        irq;
  logic        wake;
  logic [31:0] rd;
  int          fails;
  int          n_tests;
  // Plain register accesses: write, then read back
  pwt_row_t rows [20] = '{
    '{1'b0, 8'h00, 4'hF, 32'h0, 32'h0}, '{1'b0, 8'h04, 4'hF, 32'h0, 32'h0},
    '{1'b0, 8'h08, 4'hF, 32'h0, 32'h0}, '{1'b0, 8'h0C, 4'hF, 32'h0, 32'h0},
    '{1'b0, 8'h10, 4'hF, 32'h0, 32'h0}, '{1'b1, 8'h08, 4'hF, 32'hFF, 32'h0},
    '{1'b0, 8'h08, 4'hF, 32'h0, 32'hFF}, '{1'b1, 8'h08, 4'hF, 32'h0, 32'h0},
    '{1'b1, 8'h00, 4'hF, 32'h10, 32'h0}, '{1'b0, 8'h10, 4'hF, 32'h0, 32'h1},
    '{1'b1, 8'h10, 4'hF, 32'h0, 32'h0}, '{1'b0, 8'h00, 4'hF, 32'h0, 32'h0},
    '{1'b1, 8'h04, 4'hF, 32'h55, 32'h0}, '{1'b0, 8'h04, 4'hF, 32'h0, 32'h0},
    '{1'b1, 8'h20, 4'hF, 32'hFF, 32'h0}, '{1'b0, 8'h20, 4'hF, 32'h0, 32'h0},
    '{1'b1, 8'h00, 4'h0, 32'h60, 32'h0}, '{1'b0, 8'h00, 4'hF, 32'h0, 32'h0},
    '{1'b1, 8'h00, 4'hF, 32'h60, 32'h0}, '{1'b0, 8'h00, 4'hF, 32'h0, 32'h60}};

  // ==========================================================
  // Design under test
  pwt_timer dut (
    .clock_i                 (clock_i),
    .rst_b_i                 (rst_b_i),
    .wb_cyc_i                (cyc),
    .wb_stb_i                (stb),
    .wb_we_i                 (we),
    .wb_adr_i                (adr),
    .wb_sel_i                (sel),
    .wb_dat_i                (wdat),
    .wb_dat_o                (rdat),
    .wb_ack_o                (ack),
    .low_power_osc_i         (src[0]),
    .external_ref_clock_i    (src[1]),
    .internal_ref_clock_i    (src[2]),
    .wait_mode_i             (wait_m),
    .deep_power_down_halt_i  (deep_m),
    .light_power_down_halt_i (light_m),
    .background_debug_i      (bdm),
    .irq_o                   (irq),
    .wake_o                  (wake)
  );

  // 40 ns clock
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  // ==========================================================
  // Tasks
  task automatic stop_test();
    if (fails == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle; a missing ack ends the run
  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d);
    int k;
    @(posedge clock_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    for (k = 0; k < 20; k++) begin
      @(posedge clock_i);
      if (ack === 1'b1) break;
    end
    rd = rdat;
    if (k == 20) begin
      fails++;
      stop_test();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, 4'hF, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 4'hF, 32'h0);
    chk(rd, e);
  endtask

  // Source edges held 4 clocks a level, slower than the synchroniser needs
  task automatic pulse(input int idx, input int n);
    repeat (n) begin
      @(posedge clock_i);
      src[idx] <= 1'b1;
      repeat (4) @(posedge clock_i);
      src[idx] <= 1'b0;
      repeat (3) @(posedge clock_i);
    end
    repeat (4) @(posedge clock_i);
  endtask

  task automatic modes(input logic w, input logic dp, input logic lt, input logic bd);
    @(posedge clock_i);
    wait_m <= w;
    deep_m <= dp;
    light_m <= lt;
    bdm <= bd;
    repeat (6) @(posedge clock_i);
  endtask

  // Outputs are registered; let them settle before looking
  task automatic outs(input logic [1:0] e);
    repeat (3) @(posedge clock_i);
    chk({30'h0, irq, wake}, {30'h0, e});
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    fails = 0;
    n_tests = 0;
    rst_b_i = 1'b0;
    {cyc, stb, we, adr, sel, wdat} = '0;
    {src, wait_m, deep_m, light_m, bdm} = '0;
    repeat (5) @(posedge clock_i);
    rst_b_i <= 1'b1;
    outs(2'b00);
    foreach (rows[i]) begin
      xfer(rows[i].w, rows[i].a, rows[i].s, rows[i].d);
      if (rows[i].w == 1'b0) chk(rd, rows[i].e);
    end
    // Wrap at modulo 2, one edge per tick
    wr(8'h08, 32'h2);
    wr(8'h00, 32'h18);
    pulse(0, 2);
    rdc(8'h04, 32'h2);
    rdc(8'h00, 32'h18);
    pulse(0, 1);
    rdc(8'h04, 32'h0);
    rdc(8'h00, 32'h98);
    outs(2'b10);
    // Zero keeps the flag, one clears it
    wr(8'h00, 32'h18);
    rdc(8'h00, 32'h98);
    wr(8'h0C, 32'h0);
    rdc(8'h0C, 32'h1);
    wr(8'h00, 32'h98);
    rdc(8'h00, 32'h18);
    outs(2'b00);
    // Masked flag gives no request
    pulse(0, 3);
    rdc(8'h0C, 32'h1);
    wr(8'h10, 32'h0);
    outs(2'b00);
    wr(8'h0C, 32'h1);
    rdc(8'h0C, 32'h0);
    // Same prescale keeps the count, a new one clears it
    pulse(0, 1);
    wr(8'h00, 32'h08);
    rdc(8'h04, 32'h1);
    wr(8'h00, 32'h09);
    rdc(8'h04, 32'h0);
    // Code 1 divides by 8; a modulo write clears the prescaler too
    wr(8'h00, 32'h01);
    pulse(0, 5);
    wr(8'h08, 32'h2);
    pulse(0, 5);
    rdc(8'h04, 32'h0);
    pulse(0, 3);
    rdc(8'h04, 32'h1);
    // Code 0 is off
    wr(8'h00, 32'h00);
    pulse(0, 3);
    rdc(8'h04, 32'h0);
    // Debug freezes and resumes
    wr(8'h00, 32'h08);
    pulse(0, 1);
    modes(1'b0, 1'b0, 1'b0, 1'b1);
    pulse(0, 2);
    rdc(8'h04, 32'h1);
    modes(1'b0, 1'b0, 1'b0, 1'b0);
    pulse(0, 1);
    rdc(8'h04, 32'h2);
    // Internal reference source, source change alone keeps the count
    wr(8'h00, 32'h48);
    pulse(2, 1);
    rdc(8'h04, 32'h0);
    wr(8'h0C, 32'h1);
    // External source, code 1 in the fast column is 1024 edges
    wr(8'h00, 32'h21);
    pulse(1, 1023);
    rdc(8'h04, 32'h0);
    pulse(1, 1);
    rdc(8'h04, 32'h1);
    // Wake requests per power mode and source
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h18);
    pulse(0, 1);
    outs(2'b10);
    modes(1'b1, 1'b0, 1'b0, 1'b0);
    outs(2'b11);
    modes(1'b0, 1'b1, 1'b0, 1'b0);
    outs(2'b11);
    wr(8'h00, 32'h38);
    outs(2'b10);
    modes(1'b0, 1'b0, 1'b1, 1'b0);
    outs(2'b11);
    wr(8'h00, 32'h30);
    outs(2'b10);
    // Software stopped the timer before wait: no wake from it
    modes(1'b1, 1'b0, 1'b0, 1'b0);
    outs(2'b10);
    // Match and a clearing write taken on one edge: the set must win
    wr(8'h00, 32'h08);
    wr(8'h0C, 32'h1);
    @(posedge clock_i);
    src[0] <= 1'b1;
    // Edge reaches the counter three clocks later, as the write is taken
    @(posedge clock_i);
    wr(8'h0C, 32'h1);
    src[0] <= 1'b0;
    rdc(8'h0C, 32'h1);
    stop_test();
  end
endmodule // tb_top
